//--- src/dscfg_if.sv
// Interface carrying raw and latched strap levels between decoder modules
`timescale 1ns/10ps
interface dscfg_if;
   import dscfg_pkg::*;
   dscfg_strap_s raw;
   dscfg_strap_s held;
   modport latch (input raw, output held);
   modport user (output raw, input held);
endinterface

//--- src/dscfg_pkg.sv
// Package of constants and types for the drive strap configuration decoder
package dscfg_pkg;
   // Wishbone register byte offsets
   localparam logic [3:0] DSCFG_OFS_STATUS = 4'h0;
   localparam logic [3:0] DSCFG_OFS_CTRL = 4'h4;
   localparam logic [3:0] DSCFG_OFS_MAXLBA = 4'h8;
   localparam logic [3:0] DSCFG_OFS_GEOM = 4'hC;
   // Status field positions
   localparam int DSCFG_ST_ADDR = 0;
   localparam int DSCFG_ST_CABLE_SELECT_INPUT = 1;
   localparam int DSCFG_ST_HEAD15 = 2;
   localparam int DSCFG_ST_CLIP = 3;
   localparam int DSCFG_ST_STBY = 4;
   localparam int DSCFG_ST_SPIN = 5;
   localparam int DSCFG_ST_DEV1 = 6;
   localparam int DSCFG_ST_DDONE = 7;
   // Control field positions
   localparam int DSCFG_CT_SPINUP = 0;
   localparam int DSCFG_CT_SPINDN = 1;
   // Geometry field positions
   localparam int DSCFG_GE_CYL_LSB = 0;
   localparam int DSCFG_GE_HEAD_LSB = 16;
   localparam int DSCFG_GE_SECT_LSB = 24;
   // Geometry and capacity figures
   localparam logic [15:0] DSCFG_CHS_CYL = 16'h3FFF;
   localparam logic [4:0] DSCFG_HEADS_NORMAL = 5'h10;
   localparam logic [4:0] DSCFG_HEADS_REDUCED = 5'h0F;
   localparam logic [7:0] DSCFG_CHS_SECT = 8'h3F;
   localparam logic [31:0] DSCFG_CLIP_LBA = 32'h03EF_EC50;
   // Spin-up feature subcommand
   localparam logic [7:0] DSCFG_SUB_SPINUP = 8'h07;
   // Timing
   localparam int DSCFG_CLK_MHZ = 50;
   localparam int DSCFG_DETECT_US = 1000;
   localparam int DSCFG_DETECT_CYC = DSCFG_DETECT_US * DSCFG_CLK_MHZ;
   // Strap inputs, a set bit means the strap is fitted
   typedef struct packed {
      logic ab;
      logic cd;
      logic ef;
      logic head15;
      logic clip;
      logic stby;
      logic cable_select_input;
   } dscfg_strap_s;
   // Spindle control states
   typedef enum logic [2:0] {
      DSCFG_INIT = 3'b001,
      DSCFG_STOPPED = 3'b010,
      DSCFG_RUNNING = 3'b100
   } dscfg_spin_e;
endpackage

//--- src/dscfg_strap_latch.sv
// Strap latch: follows the pins during reset and freezes them at release
`timescale 1ns/10ps
module dscfg_strap_latch
   import dscfg_pkg::*;
(
   input wire logic CLK,
   input wire logic RST,
   dscfg_if.latch straps
);
   import dscfg_pkg::*;

   dscfg_strap_s held_reg;

   // Sampled only while reset is high, so a jumper moved later has no effect
   always_ff @(posedge CLK)
   begin
      if (RST)
      begin
         held_reg <= straps.raw;
      end
   end

   assign straps.held = held_reg;
endmodule

//--- src/dscfg_top.sv
// Drive strap configuration decoder with classic Wishbone register slave
//
// The implementer's own choices: the Wishbone register port and the placing of the registers.
`timescale 1ns/10ps
module dscfg_top
   import dscfg_pkg::*;
#(
   parameter logic [31:0] NATIVE_MAX_LBA = 32'h1000_0000,
   parameter int DETECT_CYC = dscfg_pkg::DSCFG_DETECT_CYC
)
(
   input wire logic CLK,
   input wire logic RST,
   input wire logic STRAP_AB,
   input wire logic STRAP_CD,
   input wire logic STRAP_EF,
   input wire logic STRAP_HEAD15,
   input wire logic STRAP_CLIP,
   input wire logic STRAP_STANDBY,
   input wire logic CABLE_SELECT_INPUT,
   input wire logic DEV1_PRESENT,
   input wire logic FEAT_VALID,
   input wire logic [7:0] FEAT_SUBCMD,
   output logic DEV_ADDR,
   output logic CABLE_SELECT_INPUT_MODE,
   output logic [4:0] HEAD_COUNT,
   output logic [31:0] MAX_LBA,
   output logic [15:0] CHS_CYL,
   output logic [7:0] CHS_SECT,
   output logic SPINDLE_RUN,
   output logic DEV1_FOUND,
   input wire logic WB_CYC_I,
   input wire logic WB_STB_I,
   input wire logic WB_WE_I,
   input wire logic [3:0] WB_ADR_I,
   input wire logic [3:0] WB_SEL_I,
   input wire logic [31:0] WB_DAT_I,
   output logic [31:0] WB_DAT_O,
   output logic WB_ACK_O
);
   import dscfg_pkg::*;

   // Counter wide enough to reach the full window length
   localparam int DCW = $clog2(DETECT_CYC + 1);
   localparam logic [DCW-1:0] DETECT_LAST = DCW'(DETECT_CYC - 1);

   dscfg_if straps ();

   // Raw pins into the latch
   assign straps.raw = '{ab: STRAP_AB, cd: STRAP_CD, ef: STRAP_EF, head15: STRAP_HEAD15,
                         clip: STRAP_CLIP, stby: STRAP_STANDBY, cable_select_input: CABLE_SELECT_INPUT};

   dscfg_strap_latch u_latch
   (
      .CLK(CLK),
      .RST(RST),
      .straps(straps)
   );

   // Frozen strap set; every decode below reads only this copy
   dscfg_strap_s h;
   assign h = straps.held;

   // Address decode from the latched straps
   wire cable_select_input_mode = h.ef;
   wire cable_select_input_addr = h.cable_select_input;
   // Without E-F only A-B selects address 1; factory C-D gives address 0
   wire strap_addr = h.ab & ~h.cd;
   wire dev_addr = cable_select_input_mode ? cable_select_input_addr : strap_addr;
   // Both A-B and C-D stand in for a partner that never answers the probe
   wire slave_forced = ~cable_select_input_mode & h.ab & h.cd;

   // Reported geometry and capacity
   wire [4:0] head_count = h.head15 ? DSCFG_HEADS_REDUCED : DSCFG_HEADS_NORMAL;
   wire clip_hit = h.clip & (NATIVE_MAX_LBA > DSCFG_CLIP_LBA);
   wire [31:0] max_lba = clip_hit ? DSCFG_CLIP_LBA : NATIVE_MAX_LBA;

   // Wishbone decode
   wire wb_req = WB_CYC_I & WB_STB_I & ~WB_ACK_O;
   wire wb_wr = wb_req & WB_WE_I;
   // Control bits ride in byte lane 0 only; other lanes are ignored
   wire hit_ctrl = WB_ADR_I == DSCFG_OFS_CTRL;
   wire sw_spinup = wb_wr & hit_ctrl & WB_SEL_I[0] & WB_DAT_I[DSCFG_CT_SPINUP];
   wire sw_spindn = wb_wr & hit_ctrl & WB_SEL_I[0] & WB_DAT_I[DSCFG_CT_SPINDN];
   wire host_spinup = FEAT_VALID & (FEAT_SUBCMD == DSCFG_SUB_SPINUP);

   // Spindle control
   dscfg_spin_e spin_reg;
   dscfg_spin_e spin_next;

   always_comb
   begin
      spin_next = spin_reg;
      unique case (spin_reg)
         DSCFG_INIT:
         begin
            // Latched straps are valid from the first cycle after release
            // A host spin-up strobe landing in this first cycle is not lost; a software one is
            spin_next = (h.stby & ~host_spinup) ? DSCFG_STOPPED : DSCFG_RUNNING;
         end
         DSCFG_STOPPED:
         begin
            if (host_spinup | sw_spinup)
            begin
               spin_next = DSCFG_RUNNING;
            end
         end
         DSCFG_RUNNING:
         begin
            // Host spin-up outranks a software spin-down in the same cycle
            if (sw_spindn & ~host_spinup)
            begin
               spin_next = DSCFG_STOPPED;
            end
         end
         default:
         begin
            spin_next = DSCFG_INIT;
         end
      endcase
   end

   // State register
   always_ff @(posedge CLK)
   begin
      if (RST)
         spin_reg <= DSCFG_INIT;
      else
         spin_reg <= spin_next;
   end

   // Device-1 presence watch window after reset, address 0 only
   logic [DCW-1:0] det_cnt_reg;
   logic det_done_reg;
   logic dev1_reg;
   wire det_open = ~det_done_reg & ~dev_addr;

   always_ff @(posedge CLK)
   begin
      if (RST)
      begin
         det_cnt_reg <= '0;
         det_done_reg <= 1'b0;
         dev1_reg <= 1'b0;
      end
      else
      begin
         if (det_open)
         begin
            // Window closes for good at the last count; a late partner is missed
            det_cnt_reg <= det_cnt_reg + DCW'(1);
            det_done_reg <= det_cnt_reg == DETECT_LAST;
            // A forced-present strap counts as a detected partner
            dev1_reg <= dev1_reg | DEV1_PRESENT | slave_forced;
         end
      end
   end

   // Register read mux
   // Unmapped offsets read as zero rather than stall the bus
   wire [31:0] status_word = {24'h00_0000, det_done_reg, dev1_reg,
                              spin_reg == DSCFG_RUNNING, h.stby, clip_hit, h.head15,
                              cable_select_input_mode, dev_addr};
   wire [31:0] geom_word = {DSCFG_CHS_SECT, 3'h0, DSCFG_HEADS_NORMAL, DSCFG_CHS_CYL};
   wire [31:0] rd_word =
      (WB_ADR_I == DSCFG_OFS_STATUS) ? status_word :
      (WB_ADR_I == DSCFG_OFS_MAXLBA) ? max_lba :
      (WB_ADR_I == DSCFG_OFS_GEOM) ? geom_word : 32'h0000_0000;

   // One-cycle answer; unmapped addresses ack with zero data
   always_ff @(posedge CLK)
   begin
      if (RST)
      begin
         WB_ACK_O <= 1'b0;
         WB_DAT_O <= '0;
      end
      else
      begin
         WB_ACK_O <= wb_req;
         WB_DAT_O <= (wb_req & ~WB_WE_I) ? rd_word : 32'h0000_0000;
      end
   end

   // Configuration outputs, registered so they only change at an edge
   // Size reads zero in reset so no host trusts a half-decoded capacity
   always_ff @(posedge CLK)
   begin
      if (RST)
      begin
         DEV_ADDR <= 1'b0;
         CABLE_SELECT_INPUT_MODE <= 1'b0;
         HEAD_COUNT <= DSCFG_HEADS_NORMAL;
         MAX_LBA <= '0;
         SPINDLE_RUN <= 1'b0;
         DEV1_FOUND <= 1'b0;
      end
      else
      begin
         DEV_ADDR <= dev_addr;
         CABLE_SELECT_INPUT_MODE <= cable_select_input_mode;
         HEAD_COUNT <= head_count;
         MAX_LBA <= max_lba;
         SPINDLE_RUN <= spin_next == DSCFG_RUNNING;
         DEV1_FOUND <= dev1_reg;
      end
   end

   // Geometry never changes with the clip
   assign CHS_CYL = DSCFG_CHS_CYL;
   assign CHS_SECT = DSCFG_CHS_SECT;
endmodule

//--- testbench/dscfg_assertions.sv
// Port-level assertions for the strap decoder
`timescale 1ns/10ps
module dscfg_chk
#(
   parameter logic [31:0] NATIVE_MAX_LBA = 32'h1000_0000
)
(
   input wire logic CLK,
   input wire logic RST,
   input wire logic STRAP_AB,
   input wire logic STRAP_EF,
   input wire logic STRAP_HEAD15,
   input wire logic STRAP_CLIP,
   input wire logic CABLE_SELECT_INPUT,
   input wire logic FEAT_VALID,
   input wire logic [7:0] FEAT_SUBCMD,
   input wire logic DEV_ADDR,
   input wire logic CABLE_SELECT_INPUT_MODE,
   input wire logic [4:0] HEAD_COUNT,
   input wire logic [31:0] MAX_LBA,
   input wire logic [15:0] CHS_CYL,
   input wire logic [7:0] CHS_SECT,
   input wire logic SPINDLE_RUN,
   input wire logic DEV1_FOUND
);
   // One domain; straps are judged two samples back, at the last reset edge
   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (RST);
   property p_mode; $fell(RST) |=> CABLE_SELECT_INPUT_MODE == $past(STRAP_EF, 2); endproperty
   a_mode: assert property (p_mode) else $error("bad mode");
   property p_cable_select_input;
      $fell(RST) && $past(STRAP_EF) |=> DEV_ADDR == $past(CABLE_SELECT_INPUT, 2);
   endproperty
   a_cable_select_input: assert property (p_cable_select_input) else $error("bad cable_select_input address");
   property p_fact; $fell(RST) && !$past(STRAP_AB) && !$past(STRAP_EF) |=> !DEV_ADDR; endproperty
   a_fact: assert property (p_fact) else $error("bad default address");
   property p_head;
      $fell(RST) |=> HEAD_COUNT == ($past(STRAP_HEAD15, 2) ? 5'h0F : 5'h10);
   endproperty
   a_head: assert property (p_head) else $error("bad head count");
   property p_lba;
      $fell(RST) |=> MAX_LBA == ($past(STRAP_CLIP, 2) ? 32'h03EF_EC50 : NATIVE_MAX_LBA);
   endproperty
   a_lba: assert property (p_lba) else $error("bad max block");
   property p_geom; CHS_CYL == 16'h3FFF && CHS_SECT == 8'h3F; endproperty
   a_geom: assert property (p_geom) else $error("geometry moved");
   property p_spin; FEAT_VALID && FEAT_SUBCMD == 8'h07 |=> SPINDLE_RUN; endproperty
   a_spin: assert property (p_spin) else $error("no spin-up");
   property p_dev1; DEV1_FOUND |-> !DEV_ADDR; endproperty
   a_dev1: assert property (p_dev1) else $error("detect at address 1");
   // Once settled, nothing may follow the pins until the next reset
   property p_hold;
      !$past(RST) && !$past(RST, 2) |-> $stable(DEV_ADDR) && $stable(CABLE_SELECT_INPUT_MODE)
         && $stable(HEAD_COUNT) && $stable(MAX_LBA);
   endproperty
   a_hold: assert property (p_hold) else $error("config moved");
endmodule
bind dscfg_top dscfg_chk #(.NATIVE_MAX_LBA(NATIVE_MAX_LBA)) chk_u (.CLK, .RST, .STRAP_AB,
   .STRAP_EF, .STRAP_HEAD15, .STRAP_CLIP, .CABLE_SELECT_INPUT, .FEAT_VALID, .FEAT_SUBCMD,
   .DEV_ADDR, .CABLE_SELECT_INPUT_MODE, .HEAD_COUNT, .MAX_LBA, .CHS_CYL, .CHS_SECT, .SPINDLE_RUN,
   .DEV1_FOUND);

//--- testbench/dscfg_host_model.sv
// Host adapter model: feature strobe and second-drive presence
`timescale 1ns/10ps
module dscfg_host_model
(
   input wire logic clk,
   input wire logic go,
   input wire logic [7:0] sub,
   input wire logic dev1,
   output logic feat_valid = 1'b0,
   output logic [7:0] feat_subcmd = 8'h00,
   output logic dev1_present = 1'b0
);
   // Idle code lines toggle so a stale 07h never lingers
   always @(posedge clk)
   begin
      feat_valid <= go;
      feat_subcmd <= go ? sub : ~feat_subcmd;
      dev1_present <= dev1;
   end
endmodule

//--- testbench/tb_top.sv
// Self-checking bench for the strap decoder
`timescale 1ns/10ps
module tb_top;
   import dscfg_pkg::*;
   logic CLK = 1'b0;
   logic RST = 1'b1;
   logic req = 1'b0;
   logic we = 1'b0;
   logic go = 1'b0;
   logic pres = 1'b0;
   logic [3:0] adr = 4'h0;
   logic [7:0] sub = 8'h00;
   logic [6:0] st = 7'h00;
   logic [31:0] wdat = 32'h0;
   logic [31:0] rdat;
   logic ack, spin, fv, dp, d1, ad;
   logic [7:0] fs;
   logic [15:0] cyl;
   logic [7:0] sect;
   logic d1f;
   logic [6:0] e;
   logic [31:0] eq[$];
   logic [31:0] mq[$];
   int fail_count = 0;
   int check_count = 0;
   int cyc_n = 0;
   int seed = 69142;
   always #10 CLK = ~CLK;
   dscfg_host_model host_u (.clk(CLK), .go, .sub, .dev1(pres), .feat_valid(fv),
      .feat_subcmd(fs), .dev1_present(dp));
   dscfg_top #(.DETECT_CYC(8)) dut_u (.CLK, .RST, .STRAP_AB(st[6]), .STRAP_CD(st[5]),
      .STRAP_EF(st[4]), .STRAP_HEAD15(st[3]), .STRAP_CLIP(st[2]), .STRAP_STANDBY(st[1]),
      .CABLE_SELECT_INPUT(st[0]), .DEV1_PRESENT(dp), .FEAT_VALID(fv), .FEAT_SUBCMD(fs),
      .DEV_ADDR(), .CABLE_SELECT_INPUT_MODE(), .HEAD_COUNT(), .MAX_LBA(), .CHS_CYL(cyl), .CHS_SECT(sect),
      .SPINDLE_RUN(spin), .DEV1_FOUND(d1f), .WB_CYC_I(req), .WB_STB_I(req), .WB_WE_I(we),
      .WB_ADR_I(adr), .WB_SEL_I(4'hF), .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack));
   task automatic chk(input logic [31:0] g, input logic [31:0] x);
      check_count++;
      if (g !== x)
      begin
         fail_count++;
         $display("mismatch at %0t: got %h exp %h", $time, g, x);
      end
   endtask
   task automatic wrap_up();
      $display("checks %0d errors %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   // Classic cycle: request held until ack is sampled, then one idle cycle
   task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
      req <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      do @(posedge CLK); while (ack !== 1'b1);
      req <= 1'b0;
      @(posedge CLK);
   endtask
   task automatic rd(input logic [3:0] a, input logic [31:0] x, input logic [31:0] m);
      eq.push_back(x & m);
      mq.push_back(m);
      wb(1'b0, a, 32'h0);
   endtask
   task automatic feat(input logic [7:0] s);
      go <= 1'b1;
      sub <= s;
      @(posedge CLK);
      go <= 1'b0;
      repeat (3) @(posedge CLK);
   endtask
   // Read answers meet the oldest note; a hang ends the run
   always @(posedge CLK)
   begin
      cyc_n++;
      if (ack === 1'b1 && we === 1'b0)
         chk(rdat & mq.pop_front(), eq.pop_front());
      if (cyc_n == 3000)
      begin
         fail_count++;
         wrap_up();
      end
   end
   initial
   begin
      @(posedge CLK);
      for (int r = 0; r < 12; r++)
      begin
         RST <= 1'b1;
         st <= (r == 0) ? 7'h00 : 7'($random(seed));
         pres <= r[0];
         repeat (3) @(posedge CLK);
         RST <= 1'b0;
         e = st;
         ad = e[4] ? e[0] : (e[6] & ~e[5]);
         d1 = ~ad & (pres | (e[6] & e[5] & ~e[4]));
         repeat (20) @(posedge CLK);
         chk({8'h00, sect, cyl}, {8'h00, 8'h3F, 16'h3FFF});
         chk({31'h0, d1f}, {31'h0, d1});
         st <= ~st;
         rd(DSCFG_OFS_STATUS, {24'h0, !ad, d1, !e[1], e[1], e[2], e[3], e[4], ad}, 32'hFF);
         rd(DSCFG_OFS_MAXLBA, e[2] ? 32'h03EF_EC50 : 32'h1000_0000, 32'hFFFF_FFFF);
         rd(DSCFG_OFS_GEOM, 32'h3F10_3FFF, 32'hFFFF_FFFF);
         wb(1'b1, 4'h2, 32'($random(seed)));
         rd(4'h2, 32'h0, 32'hFFFF_FFFF);
         chk(spin, !e[1]);
         wb(1'b1, DSCFG_OFS_CTRL, 32'h2);
         feat(8'h06);
         chk(spin, 32'h0);
         feat(8'h07);
         chk(spin, 32'h1);
      end
      wrap_up();
   end
endmodule
